// ---- esm_asserts.sv ----
// Pin and bus checks for the multiplier block
`timescale 1ns/10ps
module esm_asserts (
	input wire        mclk,
	input wire        rst,
	input wire        aclr,
	input wire        ena,
	input wire [17:0] data_a,
	input wire [17:0] data_b,
	input wire        sign_a,
	input wire        sign_b,
	input wire [35:0] result,
	input wire        result_signed,
	input wire [4:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire        avs_waitrequest
);
	reg  [8:0]  pv;
	reg  [6:0]  c;
	wire        req = avs_read | avs_write;
	wire        req_wait = req & avs_waitrequest;
	wire        ea = sign_a & c[3];
	wire        eb = sign_b & c[3];
	wire [35:0] ps = $signed({ea & data_a[17], data_a})
		* $signed({eb & data_b[17], data_b});
	wire [17:0] p0 = $signed({ea & data_a[8], data_a[8:0]})
		* $signed({eb & data_b[8], data_b[8:0]});
	wire [17:0] p1 = $signed({ea & data_a[17], data_a[17:9]})
		* $signed({eb & data_b[17], data_b[17:9]});
	wire [35:0] e = c[0] ? {p1, p0} : ps;
	wire        st = pv[6:0] == c && !aclr && !pv[7] && !c[4];
	// Shadow of the mode register, so checks follow the live setup
	always @(posedge mclk)
	begin
		pv <= {ena, aclr | rst, c};
		if (rst)
			c <= 7'h00;
		else if (avs_write && !avs_waitrequest && avs_address == 5'h00)
			c <= avs_byteenable[0] ? avs_writedata[6:0] : c;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_wait_first: assert property (req && !$past(req_wait)
		|-> avs_waitrequest) else $error("no wait state");
	chk_wait_once: assert property (req && avs_waitrequest
		|=> !avs_waitrequest) else $error("wait too long");
	chk_comb_single: assert property (c[2:0] == 3'h0 && !c[4]
		|-> result == ps) else $error("single product");
	chk_comb_dual: assert property (c[2:0] == 3'h1 && !c[4]
		|-> result == e) else $error("dual product");
	chk_sign_flag: assert property (c[2:1] == 2'h0 && !c[4]
		|-> result_signed == (ea | eb)) else $error("sign flag");
	chk_clear_zero: assert property (aclr && c[2]
		|-> result == 36'h0) else $error("clear");
	chk_hold_ena: assert property (c[2] && st && !pv[8]
		|-> $stable(result)) else $error("hold");
	chk_out_lat: assert property (c[2:1] == 2'h2 && st && pv[8]
		|-> result == $past(e)) else $error("out latency");
	chk_in_lat: assert property (c[2:1] == 2'h1 && st && pv[8]
		|-> result == $past(e)) else $error("in latency");
endmodule

// ---- esm_map.vh ----
// Register map, field positions and reset values of the multiplier block
`ifndef ESM_MAP_VH
`define ESM_MAP_VH

`define ESM_ADR_CTRL      5'h00
`define ESM_ADR_STATUS    5'h04
`define ESM_ADR_PROD_LO   5'h08
`define ESM_ADR_PROD_HI   5'h0c
`define ESM_ADR_OPA       5'h10
`define ESM_ADR_OPB       5'h14
`define ESM_ADR_COUNT     5'h18

`define ESM_CTRL_W        7
`define ESM_CTRL_DUAL     0
`define ESM_CTRL_INREG    1
`define ESM_CTRL_OUTREG   2
`define ESM_CTRL_SIGNUSE  3
`define ESM_CTRL_SWSRC    4
`define ESM_CTRL_SWSA     5
`define ESM_CTRL_SWSB     6
`define ESM_CTRL_RST      7'h00

`define ESM_ST_CAPT       0
`define ESM_ST_SIGNED     1
`define ESM_ST_DUAL       2

`define ESM_OPD_W         18
`define ESM_HALF_W        9
`define ESM_PROD_W        36
`define ESM_SEC_W         18
`define ESM_OPD_RST       18'h00000
`define ESM_COUNT_RST     16'h0000

`endif

// ---- esm_smul.v ----
// Multiplier core with per-operand signed or unsigned interpretation
`timescale 1ns/10ps
module esm_smul #(
	parameter W = 9
) (
	input  wire [W-1:0]   a,
	input  wire [W-1:0]   b,
	input  wire           sa,
	input  wire           sb,
	output wire [2*W-1:0] p
);
	// One extra bit per operand lets one signed product cover all four
	// sign mixes; the top two bits are always redundant
	wire signed [W:0]     ax;
	wire signed [W:0]     bx;
	wire signed [2*W+1:0] full;

	assign ax   = {sa & a[W-1], a};
	assign bx   = {sb & b[W-1], b};
	assign full = ax * bx;
	assign p    = full[2*W-1:0];
endmodule

// ---- esm_stage.v ----
// Optional pipeline register with shared clock, enable and async clear
`timescale 1ns/10ps
module esm_stage #(
	parameter W = 18
) (
	input  wire         mclk,
	input  wire         rst,
	input  wire         aclr,
	input  wire         ena,
	input  wire         bypass,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] held;

	always @(posedge mclk or posedge aclr)
	begin
		if (aclr)
			held <= {W{1'b0}}; // RL12
		else if (rst)
			held <= {W{1'b0}};
		else if (ena)
			held <= d; // RL9
	end

	// Bypassed stage passes data straight through
	assign q = bypass ? d : held; // RL13
endmodule

// ---- esm_top.v ----
// Embedded signed multiplier: datapath, register stages and Avalon slave
//
// Contract
// RL1: Product signed if either operand is signed
// RL2: One sign input each; high means signed
// RL3: Dual mode shares sign inputs across halves
// RL4: Sign inputs may change at run time
// RL5: Sign inputs optionally pass input register
// RL6: Full-precision product for every sign mix
// RL7: Unused sign inputs default to unsigned
// RL8: Output registers in 18-bit sections per mode
// RL9: Output registers have clock, enable, clear
// RL10: All stages share clock, enable, clear
// RL11: Modes: one 18x18 or two 9x9
// RL12: Async clear zeroes all stage registers
// RL13: Disabled register holds; bypass is combinational
`timescale 1ns/10ps
`include "esm_map.vh"
module esm_top (
	input  wire        mclk,
	input  wire        rst,
	input  wire        aclr,
	input  wire        ena,
	input  wire [17:0] data_a,
	input  wire [17:0] data_b,
	input  wire        sign_a,
	input  wire        sign_b,
	output wire [35:0] result,
	output wire        result_signed,
	input  wire [4:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest
);
	// Merge write data into a register under the byte enables
	function [31:0] be_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  be;
		integer      i;
		begin
			be_merge = old;
			for (i = 0; i < 4; i = i + 1)
			begin
				if (be[i])
					be_merge[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction

	reg  [`ESM_CTRL_W-1:0] ctrl;
	reg  [17:0]            opa;
	reg  [17:0]            opb;
	reg                    capt;
	reg  [15:0]            load_count;
	reg  [3:0]             hi_shadow;
	reg                    ack;

	wire        bus_req;
	wire        wr_take;
	wire        rd_take;
	wire [31:0] ctrl_word;
	wire [31:0] opa_word;
	wire [31:0] opb_word;
	wire [31:0] ctrl_merged;
	wire [31:0] opa_merged;
	wire [31:0] opb_merged;

	wire        mode_dual;
	wire        in_bypass;
	wire        out_bypass;
	wire        sign_use;
	wire        sw_src;

	wire [17:0] src_a;
	wire [17:0] src_b;
	wire        src_sa;
	wire        src_sb;
	wire        eff_sa;
	wire        eff_sb;

	wire [37:0] in_d;
	wire [37:0] in_q;
	wire [17:0] op_a;
	wire [17:0] op_b;
	wire        op_sa;
	wire        op_sb;

	wire [35:0] p_full;
	wire [17:0] p_lo9;
	wire [17:0] p_hi9;
	wire [35:0] prod;
	wire        prod_signed;

	wire [17:0] sec_lo_q;
	wire [18:0] sec_hi_q;
	wire        out_load;

	assign mode_dual  = ctrl[`ESM_CTRL_DUAL]; // RL11
	assign in_bypass  = ~ctrl[`ESM_CTRL_INREG];
	assign out_bypass = ~ctrl[`ESM_CTRL_OUTREG];
	assign sign_use   = ctrl[`ESM_CTRL_SIGNUSE];
	assign sw_src     = ctrl[`ESM_CTRL_SWSRC];

	// Operand source: user logic pins, or software operand registers
	assign src_a  = sw_src ? opa : data_a;
	assign src_b  = sw_src ? opb : data_b;
	assign src_sa = sw_src ? ctrl[`ESM_CTRL_SWSA] : sign_a; // RL2
	assign src_sb = sw_src ? ctrl[`ESM_CTRL_SWSB] : sign_b; // RL2

	// With sign inputs unused both operands read as unsigned
	assign eff_sa = src_sa & sign_use; // RL7
	assign eff_sb = src_sb & sign_use; // RL7

	// Signs travel with the operands so a change lines up with its data
	assign in_d = {eff_sa, eff_sb, src_a, src_b}; // RL5

	esm_stage #(
		.W (38)
	) u_in_stage (
		.mclk   (mclk),
		.rst    (rst),
		.aclr   (aclr),
		.ena    (ena),
		.bypass (in_bypass),
		.d      (in_d),
		.q      (in_q)
	); // RL10

	assign op_sa = in_q[37];
	assign op_sb = in_q[36];
	assign op_a  = in_q[35:18];
	assign op_b  = in_q[17:0];

	// Signs are sampled per product, so run-time changes need no reload
	esm_smul #(
		.W (`ESM_OPD_W)
	) u_mul_full (
		.a  (op_a),
		.b  (op_b),
		.sa (op_sa),
		.sb (op_sb),
		.p  (p_full)
	); // RL4 RL6

	esm_smul #(
		.W (`ESM_HALF_W)
	) u_mul_lo (
		.a  (op_a[8:0]),
		.b  (op_b[8:0]),
		.sa (op_sa),
		.sb (op_sb),
		.p  (p_lo9)
	); // RL3

	esm_smul #(
		.W (`ESM_HALF_W)
	) u_mul_hi (
		.a  (op_a[17:9]),
		.b  (op_b[17:9]),
		.sa (op_sa),
		.sb (op_sb),
		.p  (p_hi9)
	); // RL3

	assign prod        = mode_dual ? {p_hi9, p_lo9} : p_full; // RL11
	assign prod_signed = op_sa | op_sb; // RL1

	// Low section holds the low half of a wide product or one 9x9 result
	esm_stage #(
		.W (`ESM_SEC_W)
	) u_sec_lo (
		.mclk   (mclk),
		.rst    (rst),
		.aclr   (aclr),
		.ena    (ena),
		.bypass (out_bypass),
		.d      (prod[17:0]),
		.q      (sec_lo_q)
	); // RL8 RL10

	esm_stage #(
		.W (`ESM_SEC_W + 1)
	) u_sec_hi (
		.mclk   (mclk),
		.rst    (rst),
		.aclr   (aclr),
		.ena    (ena),
		.bypass (out_bypass),
		.d      ({prod_signed, prod[35:18]}),
		.q      (sec_hi_q)
	); // RL8 RL10

	assign result        = {sec_hi_q[17:0], sec_lo_q};
	assign result_signed = sec_hi_q[18];
	assign out_load      = ena & ~out_bypass & ~aclr;

	// Avalon slave: every access waits exactly one cycle
	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack;
	assign wr_take         = avs_write & ack;
	assign rd_take         = avs_read & ~ack;

	assign ctrl_word = {{(32-`ESM_CTRL_W){1'b0}}, ctrl};
	assign opa_word  = {14'h0000, opa};
	assign opb_word  = {14'h0000, opb};

	// Only implemented bits are kept, so reserved bits always read 0
	assign ctrl_merged = be_merge(ctrl_word, avs_writedata, avs_byteenable);
	assign opa_merged  = be_merge(opa_word, avs_writedata, avs_byteenable);
	assign opb_merged  = be_merge(opb_word, avs_writedata, avs_byteenable);

	always @(posedge mclk)
	begin
		if (rst)
			ack <= 1'b0;
		else
			ack <= bus_req & ~ack;
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			ctrl <= `ESM_CTRL_RST;
			opa  <= `ESM_OPD_RST;
			opb  <= `ESM_OPD_RST;
		end
		else if (wr_take)
		begin
			case (avs_address)
				`ESM_ADR_CTRL:
				begin
					ctrl <= ctrl_merged[`ESM_CTRL_W-1:0];
				end
				`ESM_ADR_OPA:
				begin
					opa <= opa_merged[17:0];
				end
				`ESM_ADR_OPB:
				begin
					opb <= opb_merged[17:0];
				end
				default:
				begin
					ctrl <= ctrl;
				end
			endcase
		end
	end

	// Capture flag: a load in the same cycle as the clear keeps it set
	always @(posedge mclk)
	begin
		if (rst)
			capt <= 1'b0;
		else if (out_load)
			capt <= 1'b1;
		else if (wr_take && avs_address == `ESM_ADR_STATUS &&
			avs_byteenable[0] && avs_writedata[`ESM_ST_CAPT])
			capt <= 1'b0;
	end

	// Load counter wraps; a write of any value clears it, load wins
	always @(posedge mclk)
	begin
		if (rst)
			load_count <= `ESM_COUNT_RST;
		else if (out_load)
			load_count <= load_count + 16'h0001;
		else if (wr_take && avs_address == `ESM_ADR_COUNT)
			load_count <= `ESM_COUNT_RST;
	end

	// Reading the low word freezes the high bits so a pair never tears
	always @(posedge mclk)
	begin
		if (rst)
			hi_shadow <= 4'h0;
		else if (rd_take && avs_address == `ESM_ADR_PROD_LO)
			hi_shadow <= result[35:32];
	end

	always @(posedge mclk)
	begin
		if (rst)
			avs_readdata <= 32'h00000000;
		else if (rd_take)
		begin
			case (avs_address)
				`ESM_ADR_CTRL:
					avs_readdata <= ctrl_word;
				`ESM_ADR_STATUS:
					avs_readdata <= {29'h00000000, mode_dual,
						result_signed, capt};
				`ESM_ADR_PROD_LO:
					avs_readdata <= result[31:0];
				`ESM_ADR_PROD_HI:
					avs_readdata <= {28'h0000000, hi_shadow};
				`ESM_ADR_OPA:
					avs_readdata <= opa_word;
				`ESM_ADR_OPB:
					avs_readdata <= opb_word;
				`ESM_ADR_COUNT:
					avs_readdata <= {16'h0000, load_count};
				default:
					avs_readdata <= 32'h00000000;
			endcase
		end
	end
endmodule

// ---- esm_user.sv ----
// User-logic model driving operands and sign controls
`timescale 1ns/10ps
module esm_user (
	input  wire        mclk,
	input  wire        run,
	input  wire [37:0] fix,
	output reg  [17:0] data_a,
	output reg  [17:0] data_b,
	output reg         sign_a,
	output reg         sign_b
);
	integer     seed = 63;
	reg  [63:0] r;
	// Fresh operands and signs every edge when free running
	always @(posedge mclk)
	begin
		r = {$random(seed), $random(seed)};
		{data_a, data_b, sign_a, sign_b} <= run ? r[37:0] : fix;
	end
endmodule

// ---- test_embedded_signed_multiplier.sv ----
// Self-checking bench for the embedded signed multiplier
`timescale 1ns/10ps
module test_embedded_signed_multiplier;
	reg         mclk = 1'h0;
	reg         rst = 1'h1;
	reg         aclr = 1'h0;
	reg         ena = 1'h1;
	reg         run = 1'h0;
	reg  [37:0] fix = 38'h0;
	reg  [4:0]  avs_address = 5'h00;
	reg         avs_read = 1'h0;
	reg         avs_write = 1'h0;
	reg  [31:0] avs_writedata = 32'h0;
	reg  [3:0]  avs_byteenable = 4'hf;
	reg  [31:0] rd;
	reg  [35:0] h [0:2];
	reg  [6:0]  c;
	reg  [41:0] modes = {7'h08, 7'h09, 7'h0a, 7'h0d, 7'h0f, 7'h06};
	wire [17:0] data_a;
	wire [17:0] data_b;
	wire        sign_a;
	wire        sign_b;
	wire [35:0] result;
	wire        result_signed;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	integer     fail_count = 0;
	integer     compares = 0;
	integer     i;
	integer     m;
	integer     k;
	esm_top  dut_u (.*);
	esm_user user_u (.*);
	initial
		forever
			#12.5 mclk = ~mclk;
	task check(input [63:0] what, input [35:0] exp, input [35:0] got);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			$display("BAD %0s exp %h got %h", what, exp, got);
			fail_count = fail_count + 1;
		end
	end
	endtask
	// Request stands until waitrequest is seen low at a rising edge
	task bus(input wr, input [4:0] a, input [31:0] d);
	begin
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge mclk);
		while (avs_waitrequest !== 1'h0)
			@(posedge mclk);
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge mclk);
	end
	endtask
	function [35:0] f(input [17:0] a, input [17:0] b, input sa, input sb);
		reg [17:0] lo;
		reg [17:0] hi;
	begin
		lo = $signed({sa & a[8], a[8:0]}) * $signed({sb & b[8], b[8:0]});
		hi = $signed({sa & a[17], a[17:9]}) * $signed({sb & b[17], b[17:9]});
		if (c[0])
			f = {hi, lo};
		else
			f = $signed({sa & a[17], a}) * $signed({sb & b[17], b});
	end
	endfunction
	task wrap_up;
	begin
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	initial
	begin
		#60000;
		fail_count = fail_count + 1;
		wrap_up;
	end
	initial
	begin
		repeat (6) @(posedge mclk);
		rst <= 1'h0;
		bus(1'h0, 5'h00, 32'h0);
		check("ctrl", 36'h0, {4'h0, rd});
		bus(1'h0, 5'h1c, 32'h0);
		check("unmap", 36'h0, {4'h0, rd});
		fix <= {18'h3ffff, 18'h00002, 2'h3};
		repeat (2) @(negedge mclk);
		check("dflt", 36'h7fffe, result);
		$display("reset test done");
		@(posedge mclk);
		run <= 1'h1;
		for (m = 0; m < 6; m = m + 1)
		begin
			c = modes[7 * (5 - m) +: 7];
			k = c[1] + c[2];
			bus(1'h1, 5'h00, {25'h0, c});
			for (i = 0; i < 30; i = i + 1)
			begin
				@(negedge mclk);
				h[2] = h[1];
				h[1] = h[0];
				h[0] = f(data_a, data_b, sign_a & c[3], sign_b & c[3]);
				if (i > 2)
					check("prod", h[k], result);
			end
			$display("mode %h done", c);
			@(posedge mclk);
		end
		@(posedge mclk);
		run <= 1'h0;
		bus(1'h1, 5'h00, 32'h0c);
		fix <= {18'h3ffff, 18'h3ffff, 2'h2};
		repeat (3) @(negedge mclk);
		check("mix", 36'hffffc0001, result);
		@(posedge mclk);
		ena <= 1'h0;
		fix <= {18'h20000, 18'h20000, 2'h3};
		repeat (3) @(negedge mclk);
		check("hold", 36'hffffc0001, result);
		@(posedge mclk);
		ena <= 1'h1;
		repeat (2) @(negedge mclk);
		check("big", 36'h400000000, result);
		@(posedge mclk);
		aclr <= 1'h1;
		@(negedge mclk);
		check("aclr", 36'h0, result);
		@(posedge mclk);
		aclr <= 1'h0;
		$display("hold test done");
		bus(1'h1, 5'h10, 32'hfffffffe);
		bus(1'h1, 5'h14, 32'h00000003);
		bus(1'h1, 5'h00, 32'h0000003c);
		bus(1'h0, 5'h10, 32'h0);
		check("opa", 36'h3fffe, {4'h0, rd});
		bus(1'h0, 5'h08, 32'h0);
		check("prodlo", 36'hfffffffa, {4'h0, rd});
		bus(1'h0, 5'h0c, 32'h0);
		check("prodhi", 36'hf, {4'h0, rd});
		ena <= 1'h0;
		bus(1'h1, 5'h04, 32'h00000001);
		bus(1'h1, 5'h18, 32'h0);
		bus(1'h0, 5'h04, 32'h0);
		check("status", 36'h2, {4'h0, rd});
		bus(1'h0, 5'h18, 32'h0);
		check("count", 36'h0, {4'h0, rd});
		ena <= 1'h1;
		$display("register test done");
		wrap_up;
	end
endmodule
bind esm_top esm_asserts chk_u (.*);
